// *** core/control_status_write_protect.sv ***
`timescale 1ns/1ps
module control_status_write_protect (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic clk_en,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic write_protect_pin,
    input  wire logic mon2_reset_output,
    input  wire logic mon3_reset_output,
    input  wire logic pot_write_req,
    input  wire logic pot_write_nv,
    output logic      pot_write_ok,
    output logic      global_write_latch,
    output logic      pot_lock_bit,
    output logic      nv_busy
);
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_SLAVE = 7'b0000010,
        ST_ADDR  = 7'b0000100,
        ST_DATA  = 7'b0001000,
        ST_READ  = 7'b0010000,
        ST_DONE  = 7'b0100000,
        ST_ABORT = 7'b1000000
    } bus_state_t;

    logic [3:0] pins_sync;
    logic       scl;
    logic       sda;
    logic       wp;
    logic       mon2_hi;
    logic       scl_d;
    logic       sda_d;
    logic       mon3_hi;

    // link lines idle high, protect and monitor pins idle low
    pin_sync #(.WIDTH(4), .RESET_VAL(4'hC)) u_sync (
        .clk      (clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .async_in ({scl_in, sda_in, write_protect_pin, mon2_reset_output}),
        .sync_out (pins_sync)
    );
    logic [0:0] mon3_sync;
    pin_sync #(.WIDTH(1)) u_sync3 (
        .clk      (clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .async_in (mon3_reset_output),
        .sync_out (mon3_sync)
    );
    assign {scl, sda, wp, mon2_hi} = pins_sync;
    assign mon3_hi = mon3_sync[0];

    // =====================================================================
    // bus condition detection on the sampled link clock
    // =====================================================================
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    assign scl_rise   = scl & ~scl_d;
    assign scl_fall   = ~scl & scl_d;
    assign start_cond = scl & scl_d & sda_d & ~sda;
    assign stop_cond  = scl & scl_d & ~sda_d & sda;

    // =====================================================================
    // state
    // =====================================================================
    bus_state_t state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;        // 0..7 data bits, 8 = ack slot, 9 = read done
    logic [7:0] shift, next_shift;
    logic [7:0] data_byte, next_data_byte;
    logic       have_data, next_have_data;
    logic       addr_ok, next_addr_ok;        // FFh seen since the last stop condition
    logic       ack_pending, next_ack_pending;
    logic       next_sda_out, next_sda_oe;
    logic       gwl, next_gwl;
    logic       unlock, next_unlock;
    logic       lock = csr_pkg::POT_LOCK_RESET;
    logic       next_lock;
    logic       lock_nv = csr_pkg::POT_LOCK_RESET; // stands in for the nonvolatile cell
    logic       next_lock_nv;
    logic       mon2, next_mon2;
    logic       mon3, next_mon3;
    logic [31:0] nv_cnt, next_nv_cnt;
    logic       next_pot_ok;
    logic [7:0] reg_view;

    // reserved bits always read as zero
    always_comb begin
        reg_view = 8'h00;
        reg_view[csr_pkg::BIT_MON2]     = mon2;
        reg_view[csr_pkg::BIT_MON3]     = mon3;
        reg_view[csr_pkg::BIT_POT_LOCK] = lock;
        reg_view[csr_pkg::BIT_UNLOCK]   = unlock;
        reg_view[csr_pkg::BIT_GWL]      = gwl;
    end

    // =====================================================================
    // serial engine and register update
    // =====================================================================
    always_comb begin
        next_state       = state;
        next_bit_cnt     = bit_cnt;
        next_shift       = shift;
        next_data_byte   = data_byte;
        next_have_data   = have_data;
        next_addr_ok     = addr_ok;
        next_ack_pending = ack_pending;
        next_sda_out     = sda_out;
        next_sda_oe      = sda_oe;
        next_gwl         = gwl;
        next_unlock      = unlock;
        next_lock        = lock;
        next_lock_nv     = lock_nv;
        next_mon2        = mon2 & mon2_hi;
        next_mon3        = mon3 & mon3_hi;
        next_nv_cnt      = (nv_cnt != 32'd0) ? nv_cnt - 32'd1 : 32'd0;
        // pot writes: gwl needed, lock rejects, pin blocks nonvolatile ones
        next_pot_ok = pot_write_req & gwl & ~lock & ~(pot_write_nv & wp);

        if (nv_cnt == 32'd1) begin
            next_lock = lock_nv; // store completes
        end

        if (start_cond) begin
            // repeated start keeps addr_ok so random read works
            next_state     = ST_SLAVE;
            next_bit_cnt   = 4'd0;
            next_have_data = 1'b0;
            next_sda_oe    = 1'b0;
        end else if (stop_cond) begin
            next_state  = ST_IDLE;
            next_sda_oe = 1'b0;
            next_addr_ok = 1'b0;
            // commit only a complete single data byte
            if (state == ST_DONE && have_data) begin
                if (data_byte == csr_pkg::VAL_GWL_SET && !unlock) begin
                    next_gwl = 1'b1;
                end else if (data_byte == csr_pkg::VAL_GWL_CLEAR && !unlock) begin
                    next_gwl = 1'b0;
                end else if (data_byte == csr_pkg::VAL_UNLOCK && !unlock) begin
                    next_unlock = 1'b1;
                end else if (unlock && !wp) begin
                    next_mon2 = data_byte[csr_pkg::BIT_MON2] & mon2_hi;
                    next_mon3 = data_byte[csr_pkg::BIT_MON3] & mon3_hi;
                    next_gwl  = gwl | data_byte[csr_pkg::BIT_GWL];
                    if (data_byte[csr_pkg::BIT_UNLOCK]) begin
                        next_unlock = 1'b1;
                    end else begin
                        next_unlock  = 1'b0;
                        next_lock_nv = data_byte[csr_pkg::BIT_POT_LOCK];
                        next_nv_cnt  = csr_pkg::NV_WRITE_CYCLES;
                    end
                end
            end
        end else if (scl_rise && bit_cnt < 4'd8 && state != ST_READ) begin
            next_shift   = {shift[6:0], sda};
            next_bit_cnt = bit_cnt + 4'd1;
        end else if (scl_rise && state == ST_READ && bit_cnt == 4'd9) begin
            next_state = ST_IDLE; // master ack or nack; one byte then back to ST_IDLE
        end else if (scl_fall) begin
            if (ack_pending) begin
                // release after the acknowledge clock; a read drives its first data bit instead
                next_ack_pending = 1'b0;
                next_sda_oe      = 1'b0;
                next_bit_cnt     = 4'd0;
                if (state == ST_READ) begin
                    next_sda_oe  = 1'b1;
                    next_sda_out = reg_view[7];
                    next_shift   = {reg_view[6:0], 1'b0};
                    next_bit_cnt = 4'd1;
                end
            end else if (state == ST_READ && bit_cnt < 4'd8) begin
                next_sda_out = shift[7];
                next_shift   = {shift[6:0], 1'b0};
                next_bit_cnt = bit_cnt + 4'd1;
            end else if (state == ST_READ) begin
                next_sda_oe  = 1'b0; // hand line back for master ack
                next_bit_cnt = 4'd9; // keeps the last data clock apart from the ack clock
            end else if (bit_cnt == 4'd8) begin
                case (state)
                    ST_SLAVE: begin
                        if (shift[7:1] == csr_pkg::REG_SLAVE_ADDR) begin
                            next_ack_pending = 1'b1;
                            next_sda_oe      = 1'b1;
                            next_sda_out     = 1'b0;
                            next_state       = shift[0] ? (addr_ok ? ST_READ : ST_ABORT)
                                                        : ST_ADDR;
                        end else begin
                            next_state = ST_ABORT;
                        end
                    end
                    ST_ADDR: begin
                        if (shift == csr_pkg::REG_ADDR) begin
                            next_addr_ok     = 1'b1;
                            next_ack_pending = 1'b1;
                            next_sda_oe      = 1'b1;
                            next_sda_out     = 1'b0;
                            next_state       = ST_DATA;
                        end else begin
                            next_state = ST_ABORT;
                        end
                    end
                    ST_DATA: begin
                        next_data_byte = shift;
                        next_have_data = 1'b1;
                        // the byte that sets the latch must pass while it is still clear
                        next_state     = (gwl || shift == csr_pkg::VAL_GWL_SET) ? ST_DONE
                                                                               : ST_ABORT;
                        if (gwl || shift == csr_pkg::VAL_GWL_SET) begin
                            next_ack_pending = 1'b1;
                            next_sda_oe      = 1'b1;
                            next_sda_out     = 1'b0;
                        end
                    end
                    ST_DONE: begin
                        next_state = ST_ABORT; // second byte: no ack
                    end
                    default: begin
                        next_state = ST_ABORT;
                    end
                endcase
            end
        end
        if (!clk_en) begin
            next_pot_ok = pot_write_ok;
        end
    end

    // =====================================================================
    // registers; clock enable freezes everything
    // =====================================================================
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scl_d        <= 1'b1;
            sda_d        <= 1'b1;
            state        <= ST_IDLE;
            bit_cnt      <= 4'd0;
            shift        <= 8'h00;
            data_byte    <= 8'h00;
            have_data    <= 1'b0;
            addr_ok      <= 1'b0;
            ack_pending  <= 1'b0;
            sda_out      <= 1'b1;
            sda_oe       <= 1'b0;
            gwl          <= 1'b0;
            unlock       <= 1'b0;
            mon2         <= 1'b0;
            mon3         <= 1'b0;
            nv_cnt       <= 32'd0;
            pot_write_ok <= 1'b0;
        end else if (clk_en) begin
            scl_d        <= scl;
            sda_d        <= sda;
            state        <= next_state;
            bit_cnt      <= next_bit_cnt;
            shift        <= next_shift;
            data_byte    <= next_data_byte;
            have_data    <= next_have_data;
            addr_ok      <= next_addr_ok;
            ack_pending  <= next_ack_pending;
            sda_out      <= next_sda_out;
            sda_oe       <= next_sda_oe;
            gwl          <= next_gwl;
            unlock       <= next_unlock;
            mon2         <= next_mon2;
            mon3         <= next_mon3;
            nv_cnt       <= next_nv_cnt;
            pot_write_ok <= next_pot_ok;
        end
    end

    // lock is nonvolatile: reset does not touch it; the factory value comes from
    // its declared power-up value, which is the best a plain flop can do
    always_ff @(posedge clk) begin
        if (clk_en) begin
            lock    <= next_lock;
            lock_nv <= next_lock_nv;
        end
    end

    // mirrored status outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            global_write_latch <= 1'b0;
            pot_lock_bit       <= csr_pkg::POT_LOCK_RESET;
            nv_busy            <= 1'b0;
        end else if (clk_en) begin
            global_write_latch <= next_gwl;
            pot_lock_bit       <= next_lock;
            nv_busy            <= (next_nv_cnt != 32'd0);
        end
    end
endmodule

// *** core/csr_pkg.sv ***
package csr_pkg;

    // =====================================================================
    // register layout
    // =====================================================================
    localparam logic [7:0] REG_ADDR       = 8'hFF; // address byte of the register
    localparam logic [6:0] REG_SLAVE_ADDR = 7'h52; // 1010010
    localparam int         BIT_MON2       = 6;
    localparam int         BIT_MON3       = 5;
    localparam int         BIT_POT_LOCK   = 3;
    localparam int         BIT_UNLOCK     = 2;
    localparam int         BIT_GWL        = 1;
    localparam logic [7:0] VAL_GWL_SET    = 8'h02;
    localparam logic [7:0] VAL_GWL_CLEAR  = 8'h00;
    localparam logic [7:0] VAL_UNLOCK     = 8'h06;
    localparam logic [7:0] RESERVED_MASK  = 8'h91; // bits 7, 4, 0
    localparam logic       POT_LOCK_RESET = 1'b0;  // factory value

    // =====================================================================
    // timing
    // =====================================================================
    localparam int CLK_HZ      = 50000000;
    localparam int NV_WRITE_MS = 5;
    localparam int NV_WRITE_CYCLES = CLK_HZ / 1000 * NV_WRITE_MS;

endpackage

// *** core/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_sync_out;

    // =====================================================================
    // two flops per bit; stage1 is read by the second stage only
    // =====================================================================
    always_comb begin
        next_stage1   = clk_en ? async_in : stage1;
        next_sync_out = clk_en ? stage1 : sync_out;
    end

    always_ff @(posedge clk or posedge reset) begin
        // reset to the pins' idle levels so no false edge follows reset
        if (reset) begin
            stage1   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule

// *** test/bus_master_model.sv ***
`timescale 1ns/1ps
// =====================================================================
// serial bus master: open-drain data line with a pull-up
// =====================================================================
module bus_master_model (
    input  wire logic clk,
    input  wire logic sda_out,
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda_line
);
    logic m_sda;
    // the device can only pull low; a released line floats high
    assign sda_line = m_sda & ~(sda_oe & ~sda_out);
    initial begin
        scl = 1'b1;
        m_sda = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one bit: 4 cycles low then 4 high, data moves mid-low
    task automatic bit_io(input logic b, output logic r);
        wt(2);
        m_sda = b;
        wt(2);
        scl = 1'b1;
        wt(2);
        r = sda_line;
        wt(2);
        scl = 1'b0;
    endtask
    task automatic byte_out(input logic [7:0] d, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, nak);
    endtask
    task automatic start();
        m_sda = 1'b0;
        wt(4);
        scl = 1'b0;
    endtask
    // extra low time so a trailing acknowledge is released first
    task automatic rstart();
        wt(4);
        m_sda = 1'b1;
        wt(4);
        scl = 1'b1;
        wt(4);
        m_sda = 1'b0;
        wt(4);
        scl = 1'b0;
    endtask
    task automatic stop();
        wt(4);
        m_sda = 1'b0;
        wt(4);
        scl = 1'b1;
        wt(4);
        m_sda = 1'b1;
        wt(8);
    endtask
    task automatic reg_write(input logic [7:0] sa, ab, d, input logic extra,
                             output logic [3:0] nak);
        start();
        byte_out(sa, nak[3]);
        byte_out(ab, nak[2]);
        byte_out(d, nak[1]);
        nak[0] = 1'b1;
        if (extra) begin
            byte_out(d, nak[0]);
        end
        stop();
    endtask
    task automatic reg_read(output logic [7:0] d, output logic nak);
        logic n1;
        logic r;
        start();
        byte_out({csr_pkg::REG_SLAVE_ADDR, 1'b0}, n1);
        byte_out(csr_pkg::REG_ADDR, n1);
        rstart();
        byte_out({csr_pkg::REG_SLAVE_ADDR, 1'b1}, nak);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(1'b1, r);
        stop();
    endtask
endmodule

// *** test/control_status_write_protect_chk.sv ***
`timescale 1ns/1ps
module control_status_write_protect_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic write_protect_pin,
    input wire logic pot_write_req,
    input wire logic pot_write_nv,
    input wire logic pot_write_ok,
    input wire logic global_write_latch,
    input wire logic pot_lock_bit,
    input wire logic nv_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // =====================================================================
    // pot grant; the pin is synchronised, so it must have settled
    // =====================================================================
    chk_pot_needs_gwl: assert property (
        pot_write_req && clk_en |=> (!global_write_latch -> !pot_write_ok))
        else $error("pot grant with global latch clear");
    chk_pot_nv_protect: assert property (
        pot_write_req && pot_write_nv && write_protect_pin && $past(write_protect_pin, 4)
        |=> !pot_write_ok)
        else $error("nonvolatile pot grant while protected");
    chk_pot_grant: assert property (
        pot_write_req && clk_en && !write_protect_pin && !$past(write_protect_pin, 4)
        |=> pot_write_ok == (global_write_latch && !pot_lock_bit))
        else $error("pot grant mismatch");
    // =====================================================================
    // register writes take effect only after a stop, with the bus idle; the lock bit loads when the store ends
    // =====================================================================
    chk_gwl_at_stop: assert property (
        $changed(global_write_latch) |-> scl_in && sda_in)
        else $error("global latch changed off a stop");
    chk_nv_start_stop: assert property (
        $rose(nv_busy) |-> scl_in && sda_in)
        else $error("store cycle started off a stop");
    chk_nv_wp_block: assert property (
        write_protect_pin && $past(write_protect_pin, 4) |-> !$rose(nv_busy))
        else $error("store cycle started while protected");
    chk_lock_only_nv: assert property (
        !$past(reset) && !$past(nv_busy) && !$past(nv_busy, 2) |-> $stable(pot_lock_bit))
        else $error("lock bit moved outside a store cycle");
    chk_ack_stands: assert property (
        $rose(sda_oe) |=> sda_oe [*3])
        else $error("driven bit released too early");
    chk_rise_drives_low: assert property (
        $rose(sda_oe) |-> !sda_out)
        else $error("line taken without driving low");
    chk_reset_clear: assert property (
        $fell(reset) |-> !global_write_latch && !nv_busy)
        else $error("volatile state survived reset");
endmodule
bind control_status_write_protect control_status_write_protect_chk
    control_status_write_protect_chk_inst (
    .clk(clk), .reset(reset), .clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_protect_pin(write_protect_pin),
    .pot_write_req(pot_write_req), .pot_write_nv(pot_write_nv),
    .pot_write_ok(pot_write_ok), .global_write_latch(global_write_latch),
    .pot_lock_bit(pot_lock_bit), .nv_busy(nv_busy));

// *** test/control_status_write_protect_tb.sv ***
`timescale 1ns/1ps
module control_status_write_protect_tb;
    logic       clk, reset, scl, sda_line, sda_out, sda_oe, wp, mon2, mon3;
    logic       clk_en;
    logic       pot_req, pot_nv, pot_ok, gwl, lock, nv_busy;
    logic [7:0] rd_data;
    logic [3:0] nak;
    logic       rd_nak;
    int         miscompares = 0;
    int         n_tests = 0;
    int         cycles = 0;
    localparam logic [7:0] SA_W = {csr_pkg::REG_SLAVE_ADDR, 1'b0};
    localparam logic [7:0] ADDR = csr_pkg::REG_ADDR;
    // pot table entries: {nonvolatile, protect pin, expected grant}
    localparam logic [2:0] POT_TAB [4] = '{3'b001, 3'b101, 3'b110, 3'b011};

    control_status_write_protect control_status_write_protect_inst (
        .clk(clk), .reset(reset), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .write_protect_pin(wp),
        .mon2_reset_output(mon2), .mon3_reset_output(mon3), .pot_write_req(pot_req),
        .pot_write_nv(pot_nv), .pot_write_ok(pot_ok), .global_write_latch(gwl),
        .pot_lock_bit(lock), .nv_busy(nv_busy));
    bus_master_model bus_master_model_inst (
        .clk(clk), .sda_out(sda_out), .sda_oe(sda_oe), .scl(scl), .sda_line(sda_line));

    initial clk = 1'b0;
    always #10 clk = ~clk;
    // hang guard: a full run needs well under 10000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            test_done();
        end
    end
    // =====================================================================
    // shared checks and bus tasks
    // =====================================================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] sa, ab, d, input logic extra);
        bus_master_model_inst.reg_write(sa, ab, d, extra, nak);
    endtask
    task automatic rd(input logic [7:0] exp);
        bus_master_model_inst.reg_read(rd_data, rd_nak);
        chk({7'h00, rd_nak}, 8'h00);
        chk(rd_data, exp);
    endtask
    // protect pin settles through its synchroniser before the request
    task automatic pot(input logic nv, input logic wpv, input logic exp);
        wp = wpv;
        repeat (6) @(negedge clk);
        pot_req = 1'b1;
        pot_nv = nv;
        @(negedge clk);
        chk({7'h00, pot_ok}, {7'h00, exp});
        pot_req = 1'b0;
        wp = 1'b0;
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // =====================================================================
    // main sequence
    // =====================================================================
    initial begin
        reset = 1'b1;
        {wp, mon2, mon3, pot_req, pot_nv} = 5'h00;
        clk_en = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        chk({5'h00, gwl, lock, nv_busy}, 8'h00);
        rd(8'h00);
        wr(SA_W, ADDR, 8'h06, 1'b0);
        chk({4'h0, nak}, 8'h03);
        rd(8'h00);
        wr(SA_W, ADDR, 8'h02, 1'b0);
        chk({6'h00, gwl, nv_busy}, 8'h02);
        rd(8'h02);
        wr(8'hA6, ADDR, 8'h00, 1'b0);
        chk({4'h0, nak}, 8'h0F);
        wr(SA_W, 8'hFE, 8'h00, 1'b0);
        chk({4'h0, nak}, 8'h07);
        wr(SA_W, ADDR, 8'h00, 1'b1);
        chk({4'h0, nak}, 8'h01);
        chk({7'h00, gwl}, 8'h01);
        wr(SA_W, ADDR, 8'h0A, 1'b0);
        rd(8'h02);
        foreach (POT_TAB[i]) begin
            pot(POT_TAB[i][2], POT_TAB[i][1], POT_TAB[i][0]);
        end
        // a frozen block must hold its grant output until enabled again
        @(negedge clk);
        clk_en  = 1'b0;
        pot_req = 1'b1;
        repeat (3) @(negedge clk);
        chk({7'h00, pot_ok}, 8'h00);
        clk_en = 1'b1;
        @(negedge clk);
        chk({7'h00, pot_ok}, 8'h01);
        pot_req = 1'b0;
        wr(SA_W, ADDR, 8'h00, 1'b0);
        chk({7'h00, gwl}, 8'h00);
        pot(1'b0, 1'b0, 1'b0);
        mon2 = 1'b1;
        wr(SA_W, ADDR, 8'h02, 1'b0);
        wr(SA_W, ADDR, 8'h06, 1'b0);
        rd(8'h06);
        wp = 1'b1;
        wr(SA_W, ADDR, 8'h4A, 1'b0);
        chk({7'h00, nv_busy}, 8'h00);
        wp = 1'b0;
        rd(8'h06);
        wr(SA_W, ADDR, 8'h6E, 1'b0);
        rd(8'h46);
        mon2 = 1'b0;
        repeat (8) @(negedge clk);
        rd(8'h06);
        reset = 1'b1;
        @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        rd(8'h00);
        wr(SA_W, ADDR, 8'h02, 1'b0);
        wr(SA_W, ADDR, 8'h06, 1'b0);
        wr(SA_W, ADDR, 8'h02, 1'b0);
        chk({6'h00, gwl, nv_busy}, 8'h03);
        test_done();
    end
endmodule
